// ===== hdl/acip_map.svh
// constants for the accelerometer i2c target port
`ifndef ACIP_MAP_SVH
`define ACIP_MAP_SVH

// target addresses chosen by the strap
`define ACIP_TARGET_ADDR_HI 7'h1D
`define ACIP_TARGET_ADDR_LO 7'h53
// address bytes as they appear on the bus
`define ACIP_ADDR_BYTE_WR_HI 8'h3A
`define ACIP_ADDR_BYTE_RD_HI 8'h3B
`define ACIP_ADDR_BYTE_WR_LO 8'hA6
`define ACIP_ADDR_BYTE_RD_LO 8'hA7
// bus speeds and system clock
`define ACIP_SCL_STD_KHZ 100
`define ACIP_SCL_FAST_KHZ 400
`define ACIP_CLK_KHZ 25000
// core cycles in one fast scl period, rounded down
`define ACIP_FAST_SCL_CYCLES (`ACIP_CLK_KHZ / `ACIP_SCL_FAST_KHZ)
// register pointer after reset
`define ACIP_PTR_RESET 8'h00
// last bit index within a byte
`define ACIP_BIT_LAST 3'h7

`endif

// ===== hdl/acip_pkg.sv
// types for the accelerometer i2c target port
package acip_pkg;

  typedef enum logic [2:0] {
    ACIP_IDLE = 3'b000,
    ACIP_RECV = 3'b001,
    ACIP_ACK  = 3'b011,
    ACIP_SEND = 3'b010,
    ACIP_RACK = 3'b110
  } acip_state_e;

  typedef enum logic [1:0] {
    ACIP_PH_ADDR = 2'b00,
    ACIP_PH_REG  = 2'b01,
    ACIP_PH_DATA = 2'b11
  } acip_phase_e;

endpackage : acip_pkg

// ===== hdl/acip_sync.sv
// two flip-flop synchroniser with asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module acip_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule : acip_sync

`default_nettype wire

// ===== hdl/acip_target.sv
// i2c target port of the accelerometer with a register access port
// Behaviour
// R1: serial port works as i2c target while active-low chip select is high.
// R2: chip select low means spi; protocol follows that single level.
// R3: accepts standard 100 kHz and fast 400 kHz scl.
// R4: single and multiple byte register reads and writes in one transaction.
// R5: strap high answers address 0x1D, bytes 0x3A write, 0x3B read.
// R6: strap low answers address 0x53, bytes 0xA6 write, 0xA7 read.
// R7: system must drive chip select high and strap to a definite level.
// R8: host keeps sample rate at most 800 Hz at 400 kHz, scaled down.
// R9: every register is one byte; each data byte maps to one register.
// R10: first write byte sets pointer, later bytes increment it; read after repeated start.
`timescale 1ns/1ps
`default_nettype none
`include "acip_map.svh"

module acip_target
  import acip_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  input wire logic i_cs_n,
  input wire logic i_target_id_strap,
  output logic o_i2c_select,
  output logic o_spi_select,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  input wire logic [7:0] i_reg_rdata
);

  function automatic logic [6:0] acip_addr_of(input logic strap);
    acip_addr_of = strap ? `ACIP_TARGET_ADDR_HI : `ACIP_TARGET_ADDR_LO;
  endfunction : acip_addr_of

  ////////////////////////////////////////////////////////////////////////
  // link domain reset, pin and answer synchronisers

  logic link_rst_n;
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic cs_s;
  logic strap_s;
  logic ack_s;
  logic ack_q;
  logic [7:0] rdata_q;

  acip_sync #(.WIDTH(1)) u_link_rst (
    .i_clock(i_link_clk),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(link_rst_n)
  );

  acip_sync #(.WIDTH(4)) u_link_pins (
    .i_clock(i_link_clk),
    .i_rst_n(link_rst_n),
    .i_d({i_scl, i_sda, i_cs_n, i_target_id_strap}),
    .o_q(pins_s)
  );

  acip_sync #(.WIDTH(1)) u_link_ack (
    .i_clock(i_link_clk),
    .i_rst_n(link_rst_n),
    .i_d(ack_q),
    .o_q(ack_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign strap_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////
  // link domain bus condition decode

  logic scl_p_q;
  logic sda_p_q;
  logic rise_w;
  logic fall_w;
  logic start_w;
  logic stop_w;

  assign rise_w = scl_s & ~scl_p_q; // R3
  assign fall_w = ~scl_s & scl_p_q; // R3
  assign start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_w = scl_s & scl_p_q & ~sda_p_q & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // link domain byte engine

  acip_state_e state_q, state_d;
  acip_phase_e phase_q, phase_d;
  logic [2:0] cnt_q, cnt_d;
  logic full_q, full_d;
  logic [7:0] shift_q, shift_d;
  logic rw_q, rw_d;
  logic nack_q, nack_d;
  logic [6:0] my_addr_q, my_addr_d;
  logic [7:0] ptr_q, ptr_d;
  logic sda_low_q, sda_low_d;
  logic req_q, req_d;
  logic req_wr_q, req_wr_d;
  logic [7:0] req_addr_q, req_addr_d;
  logic [7:0] req_wdata_q, req_wdata_d;
  logic [7:0] rd_hold_q, rd_hold_d;
  logic ack_p_q;
  logic addr_hit_w;
  logic byte_end_w;

  assign addr_hit_w = shift_q[7:1] == my_addr_q; // R5 R6
  assign byte_end_w = (state_q == ACIP_RECV) & full_q & fall_w;
  assign rd_hold_d = (ack_s != ack_p_q) ? rdata_q : rd_hold_q;

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    cnt_d = cnt_q;
    full_d = full_q;
    shift_d = shift_q;
    rw_d = rw_q;
    nack_d = nack_q;
    my_addr_d = my_addr_q;
    ptr_d = ptr_q;
    sda_low_d = sda_low_q;
    req_d = req_q;
    req_wr_d = req_wr_q;
    req_addr_d = req_addr_q;
    req_wdata_d = req_wdata_q;
    if (!cs_s) begin
      state_d = ACIP_IDLE; // R1 R2
      sda_low_d = 1'b0;
    end else if (start_w) begin
      state_d = ACIP_RECV; // R10
      phase_d = ACIP_PH_ADDR;
      cnt_d = 3'h0;
      full_d = 1'b0;
      sda_low_d = 1'b0;
      my_addr_d = acip_addr_of(strap_s); // R5 R6
    end else if (stop_w) begin
      state_d = ACIP_IDLE;
      sda_low_d = 1'b0;
    end else begin
      case (state_q)
        ACIP_RECV: begin
          if (rise_w && !full_q) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d = cnt_q + 3'h1;
            full_d = cnt_q == `ACIP_BIT_LAST;
          end else if (byte_end_w) begin
            full_d = 1'b0;
            cnt_d = 3'h0;
            state_d = ACIP_ACK;
            sda_low_d = 1'b1;
            case (phase_q)
              ACIP_PH_ADDR: begin
                if (addr_hit_w) begin
                  rw_d = shift_q[0];
                  if (shift_q[0]) begin
                    req_d = ~req_q; // R4
                    req_wr_d = 1'b0;
                    req_addr_d = ptr_q;
                    ptr_d = ptr_q + 8'h01;
                  end
                end else begin
                  state_d = ACIP_IDLE; // R5 R6
                  sda_low_d = 1'b0;
                end
              end
              ACIP_PH_REG: begin
                ptr_d = shift_q; // R10
              end
              default: begin
                req_d = ~req_q; // R9
                req_wr_d = 1'b1;
                req_addr_d = ptr_q;
                req_wdata_d = shift_q;
                ptr_d = ptr_q + 8'h01; // R10
              end
            endcase
          end
        end
        ACIP_ACK: begin
          if (fall_w) begin
            cnt_d = 3'h0;
            if (rw_q && phase_q == ACIP_PH_ADDR) begin
              state_d = ACIP_SEND; // R4
              shift_d = rd_hold_q;
              sda_low_d = ~rd_hold_q[7];
            end else begin
              state_d = ACIP_RECV;
              sda_low_d = 1'b0;
              phase_d = (phase_q == ACIP_PH_ADDR) ? ACIP_PH_REG : ACIP_PH_DATA;
            end
          end
        end
        ACIP_SEND: begin
          if (fall_w) begin
            if (cnt_q == `ACIP_BIT_LAST) begin
              state_d = ACIP_RACK;
              sda_low_d = 1'b0;
              cnt_d = 3'h0;
              req_d = ~req_q; // R4
              req_wr_d = 1'b0;
              req_addr_d = ptr_q;
              ptr_d = ptr_q + 8'h01;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              cnt_d = cnt_q + 3'h1;
              sda_low_d = ~shift_q[6];
            end
          end
        end
        ACIP_RACK: begin
          if (rise_w) begin
            nack_d = sda_s;
          end else if (fall_w) begin
            if (nack_q) begin
              state_d = ACIP_IDLE;
            end else begin
              state_d = ACIP_SEND; // R4
              shift_d = rd_hold_q;
              sda_low_d = ~rd_hold_q[7];
            end
          end
        end
        default: begin
          sda_low_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      state_q <= ACIP_IDLE;
      phase_q <= ACIP_PH_ADDR;
      cnt_q <= 3'h0;
      full_q <= 1'b0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      my_addr_q <= `ACIP_TARGET_ADDR_LO;
      ptr_q <= `ACIP_PTR_RESET;
      sda_low_q <= 1'b0;
      req_q <= 1'b0;
      req_wr_q <= 1'b0;
      req_addr_q <= 8'h00;
      req_wdata_q <= 8'h00;
      rd_hold_q <= 8'h00;
      ack_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      shift_q <= shift_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      my_addr_q <= my_addr_d;
      ptr_q <= ptr_d;
      sda_low_q <= sda_low_d;
      req_q <= req_d;
      req_wr_q <= req_wr_d;
      req_addr_q <= req_addr_d;
      req_wdata_q <= req_wdata_d;
      rd_hold_q <= rd_hold_d;
      ack_p_q <= ack_s;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe_n = ~sda_low_q;

  ////////////////////////////////////////////////////////////////////////
  // core domain register access

  logic req_s;
  logic cs_core_s;
  logic seen_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic i2c_sel_q;
  logic new_w;

  acip_sync #(.WIDTH(2)) u_core_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_d({req_q, i_cs_n}),
    .o_q({req_s, cs_core_s})
  );

  assign new_w = req_s != seen_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
      i2c_sel_q <= 1'b0;
    end else begin
      seen_q <= req_s;
      wr_q <= new_w & req_wr_q; // R9
      rd_q <= new_w & ~req_wr_q;
      addr_q <= new_w ? req_addr_q : addr_q;
      wdata_q <= new_w ? req_wdata_q : wdata_q;
      rdata_q <= rd_q ? i_reg_rdata : rdata_q;
      ack_q <= (wr_q | rd_q) ? ~ack_q : ack_q;
      i2c_sel_q <= cs_core_s; // R1 R2
    end
  end

  assign o_reg_wr = wr_q;
  assign o_reg_rd = rd_q;
  assign o_reg_addr = addr_q;
  assign o_reg_wdata = wdata_q;
  assign o_i2c_select = i2c_sel_q;
  assign o_spi_select = ~i2c_sel_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence seq_addr_byte_end;
    byte_end_w && phase_q == ACIP_PH_ADDR && cs_s && !start_w && !stop_w;
  endsequence

  sequence seq_data_byte_end;
    byte_end_w && phase_q == ACIP_PH_DATA && cs_s && !start_w && !stop_w;
  endsequence

  chk_cs_gate_idle: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R1
    !cs_s |=> state_q == ACIP_IDLE && o_sda_oe_n)
    else $error("link engine active while chip select low");

  chk_spi_select_level: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
    cs_core_s != $past(cs_core_s) |=> o_spi_select == !$past(cs_core_s))
    else $error("protocol select does not follow chip select");

  chk_addr_hi_ack: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R5
    seq_addr_byte_end ##0 (my_addr_q == `ACIP_TARGET_ADDR_HI
      && (shift_q == `ACIP_ADDR_BYTE_WR_HI || shift_q == `ACIP_ADDR_BYTE_RD_HI))
    |=> state_q == ACIP_ACK ##1 !o_sda_oe_n)
    else $error("high strap address not acknowledged");

  chk_addr_lo_ack: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R6
    seq_addr_byte_end ##0 (my_addr_q == `ACIP_TARGET_ADDR_LO
      && (shift_q == `ACIP_ADDR_BYTE_WR_LO || shift_q == `ACIP_ADDR_BYTE_RD_LO))
    |=> state_q == ACIP_ACK && rw_q == $past(shift_q[0]))
    else $error("low strap address not acknowledged");

  chk_addr_miss_free: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R5 R6
    seq_addr_byte_end ##0 !addr_hit_w |=> state_q == ACIP_IDLE ##1 o_sda_oe_n)
    else $error("foreign address byte acknowledged");

  chk_ptr_load_step: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R10
    byte_end_w && phase_q == ACIP_PH_REG && cs_s && !start_w && !stop_w |=> ptr_q == $past(shift_q))
    else $error("register pointer not loaded from first byte");

  chk_write_one_byte: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R9 R10
    seq_data_byte_end |=> req_wdata_q == $past(shift_q) && req_addr_q == $past(ptr_q)
      && ptr_q == $past(ptr_q) + 8'h01 && req_q != $past(req_q))
    else $error("data byte not mapped to one register");

  chk_core_strobe: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R4
    new_w |=> (o_reg_wr ^ o_reg_rd) ##1 !o_reg_wr && !o_reg_rd && ack_q != $past(ack_q, 2))
    else $error("register strobe or answer missing");

  chk_send_first_bit: assert property (@(posedge i_link_clk) disable iff (!link_rst_n) // R4
    state_q == ACIP_RACK && fall_w && !nack_q && cs_s && !start_w && !stop_w
    |=> state_q == ACIP_SEND ##1 o_sda_oe_n == $past(rd_hold_q[7], 2))
    else $error("next read byte not presented");

  chk_bit_rate_sync: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R3
    o_reg_wr |-> ##1 !o_reg_wr [*6])
    else $error("register strobes closer than a byte time allows");

endmodule : acip_target

`default_nettype wire

// ===== hdl/acip_target_end.sv
// no further logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== test/acip_host.sv
// i2c bus controller model that drives scl and the open-drain sda
`timescale 1ns/1ps
`default_nettype none

module acip_host (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // quarter of an scl period in core cycles: 16 is about 390 kHz, 63 about 99 kHz
  int q = 16;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  // sda changes only while scl is low, sampled in mid high time
  task automatic bit_io(input logic b, output logic r);
    tick(q);
    o_sda_low = ~b;
    tick(q);
    o_scl = 1'b1;
    tick(q);
    r = i_sda;
    tick(q);
    o_scl = 1'b0;
  endtask : bit_io
  task automatic start();
    tick(q);
    o_sda_low = 1'b0;
    tick(q);
    o_scl = 1'b1;
    tick(q);
    o_sda_low = 1'b1;
    tick(q);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(q);
    o_sda_low = 1'b1;
    tick(q);
    o_scl = 1'b1;
    tick(q);
    o_sda_low = 1'b0;
    tick(2 * q);
  endtask : stop
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_w
  task automatic byte_r(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, r);
  endtask : byte_r
endmodule : acip_host

`default_nettype wire

// ===== test/accel_i2c_target_port_tb.sv
// self-checking bench for the accelerometer i2c target port
`timescale 1ns/1ps
`default_nettype none

module accel_i2c_target_port_tb;
  logic clk, lclk, rst_n, cs_n, strap, scl, sda_low, sda_o, sda_oe_n;
  logic i2c_sel, spi_sel, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, rdata, p;
  logic [7:0] mem [256];
  int ex [256];
  logic [15:0] wq [$];
  logic [15:0] eq [$];
  int fails = 0;
  int checks_done = 0;
  int rd_cnt = 0;
  // open-drain sda with pull-up
  wire sda = ~sda_low & (sda_oe_n | sda_o);
  assign rdata = mem[reg_addr];

  acip_target DUT (.i_clock(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_cs_n(cs_n), .i_target_id_strap(strap),
    .o_i2c_select(i2c_sel), .o_spi_select(spi_sel), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .i_reg_rdata(rdata));
  acip_host host (.i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      wq.push_back({reg_addr, reg_wdata});
    end
    if (reg_rd === 1'b1) rd_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic wr_txn(input logic [7:0] ab, input logic [7:0] pt, input int n);
    logic a;
    logic [7:0] d;
    eq.delete();
    wq.delete();
    host.start();
    host.byte_w(ab, a);
    chk("write address ack", 16'(a), 16'h0001);
    host.byte_w(pt, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host.byte_w(d, a);
      chk("write data ack", 16'(a), 16'h0001);
      ex[(pt + i) % 256] = d;
      eq.push_back({pt + 8'(i), d});
    end
    host.stop();
    chk("write count", 16'(wq.size()), 16'(n));
    while (eq.size() > 0 && wq.size() > 0) chk("write access", wq.pop_front(), eq.pop_front());
    $display("test write %h done", ab);
  endtask : wr_txn
  task automatic rd_txn(input logic [7:0] aw, input logic [7:0] pt, input int n, input logic setp);
    logic a;
    logic [7:0] d;
    int rd0;
    rd0 = rd_cnt;
    if (setp) begin
      host.start();
      host.byte_w(aw, a);
      host.byte_w(pt, a);
    end
    host.start();
    host.byte_w(aw | 8'h01, a);
    chk("read address ack", 16'(a), 16'h0001);
    for (int i = 0; i < n; i++) begin
      host.byte_r(i < n - 1, d);
      chk("read data", 16'(d), 16'(ex[(pt + i) % 256]));
    end
    host.stop();
    chk("read strobes", 16'(rd_cnt - rd0), 16'(n + 1));
    $display("test read %h done", aw);
  endtask : rd_txn
  task automatic nack_txn(input logic [7:0] ab);
    logic a;
    wq.delete();
    host.start();
    host.byte_w(ab, a);
    host.stop();
    chk("refused address ack", 16'(a), 16'h0000);
    chk("refused writes", 16'(wq.size()), 16'h0000);
    $display("test refuse %h done", ab);
  endtask : nack_txn

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    $display("unexpected run length: expected end, seen none");
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    strap = 1'b1;
    void'($urandom(8100));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      ex[i] = mem[i];
    end
    repeat (10) @(posedge clk);
    #1;
    chk("spi select in reset", 16'(spi_sel), 16'h0001);
    chk("i2c select in reset", 16'(i2c_sel), 16'h0000);
    chk("sda release in reset", 16'(sda_oe_n), 16'h0001);
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("i2c select", 16'(i2c_sel), 16'h0001);
    rd_txn(8'h3A, 8'h00, 2, 1'b0);
    p = 8'($urandom);
    wr_txn(8'h3A, p, 4);
    rd_txn(8'h3A, p, 4, 1'b1);
    wr_txn(8'h3A, 8'hFE, 3);
    rd_txn(8'h3A, 8'hFE, 3, 1'b1);
    host.q = 63;
    strap = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    nack_txn(8'h3A);
    p = 8'($urandom);
    wr_txn(8'hA6, p, 2);
    rd_txn(8'hA6, p, 2, 1'b1);
    host.q = 16;
    cs_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk("spi select", 16'(spi_sel), 16'h0001);
    chk("i2c deselect", 16'(i2c_sel), 16'h0000);
    nack_txn(8'hA6);
    cs_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk("i2c reselect", 16'(i2c_sel), 16'h0001);
    test_done();
  end
endmodule : accel_i2c_target_port_tb

`default_nettype wire
